// ### afc_avs.sv
`default_nettype none

module afc_avs (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // Block side
  input  wire logic [31:0] status,
  output logic [31:0]      config_word
);

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic [31:0] cfg;
  } afc_avs_s;

  afc_avs_s st_q;
  afc_avs_s st_d;
  logic     req;

  assign req = read | write;

  // One wait cycle: read data is captured while waitrequest is high
  always_comb begin
    st_d     = st_q;
    st_d.ack = req & ~st_q.ack;
    if (read && !st_q.ack) begin
      unique case (address)
        afc_pkg::CFG_ADDR:  st_d.rdata = st_q.cfg & afc_pkg::CFG_WMASK;
        afc_pkg::STAT_ADDR: st_d.rdata = status;
        default:            st_d.rdata = 32'h0000_0000;
      endcase
    end
    if (write && st_q.ack && address == afc_pkg::CFG_ADDR) begin
      for (int b = 0; b < 4; b++) begin
        if (byteenable[b]) begin
          st_d.cfg[b*8 +: 8] = writedata[b*8 +: 8] & afc_pkg::CFG_WMASK[b*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q     <= '0;
      st_q.cfg <= afc_pkg::CFG_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign waitrequest = req & ~st_q.ack;
  assign readdata    = st_q.rdata;
  assign config_word = st_q.cfg;

endmodule

`default_nettype wire

// ### afc_bp_timer.sv
`default_nettype none

module afc_bp_timer #(
  parameter int unsigned PERIOD_NS = afc_pkg::CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Control
  input  wire logic       start,
  input  wire logic       stop,
  input  wire logic [3:0] code,
  input  wire logic       speed_100,
  // Status
  output logic            active
);

  typedef struct packed {
    logic                          run;
    logic [afc_pkg::BP_CNT_W-1:0] cnt;
  } afc_tmr_s;

  afc_tmr_s st_q;
  afc_tmr_s st_d;

  // A running jam is not restarted by a later frame
  always_comb begin
    st_d = st_q;
    if (stop) begin
      st_d.run = 1'b0;
      st_d.cnt = '0;
    end else if (st_q.run) begin
      if (st_q.cnt <= afc_pkg::BP_CNT_W'(1)) begin
        st_d.run = 1'b0;
        st_d.cnt = '0;
      end else begin
        st_d.cnt = st_q.cnt - afc_pkg::BP_CNT_W'(1);
      end
    end else if (start) begin
      st_d.run = 1'b1;
      st_d.cnt = afc_pkg::bp_cycles(code, speed_100, PERIOD_NS);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign active = st_q.run;

endmodule

`default_nettype wire

// ### afc_flow_ctrl.sv
// Implementation choice: the Avalon-MM interface to the registers.
`default_nettype none

module afc_flow_ctrl #(
  parameter int unsigned PERIOD_NS = afc_pkg::CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic                       clock,
  input  wire logic                       rst,
  // Avalon-MM slave
  input  wire logic [7:0]                 address,
  input  wire logic                       read,
  input  wire logic                       write,
  input  wire logic [31:0]                writedata,
  input  wire logic [3:0]                 byteenable,
  output logic [31:0]                     readdata,
  output logic                            waitrequest,
  // MAC state
  input  wire logic                       tx_enable,
  input  wire logic                       full_duplex,
  input  wire logic                       speed_100,
  input  wire logic [15:0]                pause_time_value,
  input  wire logic [afc_pkg::FILL_W-1:0] rx_fifo_bytes,
  // Receive frame events
  input  wire logic                       rx_preamble,
  input  wire logic                       rx_header_valid,
  input  wire logic                       rx_is_multicast,
  input  wire logic                       rx_is_broadcast,
  input  wire logic                       rx_is_own_address,
  // Pause transmit handshake
  output logic                            pause_request,
  output logic [15:0]                     pause_time_out,
  input  wire logic                       pause_sent,
  // Half-duplex jam
  output logic                            backpressure
);

  // ************************************************************
  // Register file
  // ************************************************************
  logic [31:0] cfg;
  logic [31:0] status;

  afc_avs u_avs (
    .clock       (clock),
    .rst         (rst),
    .address     (address),
    .read        (read),
    .write       (write),
    .writedata   (writedata),
    .byteenable  (byteenable),
    .readdata    (readdata),
    .waitrequest (waitrequest),
    .status      (status),
    .config_word (cfg)
  );

  logic [7:0] flow_high_threshold;
  logic [7:0] flow_low_threshold;
  logic [3:0] backpressure_time_code;
  logic       on_multicast_enable;
  logic       on_broadcast_enable;
  logic       on_own_address_enable;
  logic       on_any_frame_enable;

  assign flow_high_threshold    = cfg[afc_pkg::HI_LSB +: 8];
  assign flow_low_threshold     = cfg[afc_pkg::LO_LSB +: 8];
  assign backpressure_time_code = cfg[afc_pkg::DUR_LSB +: 4];
  assign on_multicast_enable    = cfg[afc_pkg::MULT_BIT];
  assign on_broadcast_enable    = cfg[afc_pkg::BRD_BIT];
  assign on_own_address_enable  = cfg[afc_pkg::ADDR_BIT];
  assign on_any_frame_enable    = cfg[afc_pkg::ANY_BIT];

  // ************************************************************
  // Thresholds
  // ************************************************************
  logic high_reached;
  logic below_low;
  logic auto_enabled;

  assign high_reached = rx_fifo_bytes >= afc_pkg::thresh_bytes(flow_high_threshold);
  assign below_low    = rx_fifo_bytes < afc_pkg::thresh_bytes(flow_low_threshold);
  assign auto_enabled = on_any_frame_enable | on_multicast_enable
                      | on_broadcast_enable | on_own_address_enable;

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    afc_pkg::afc_state_e          state;
    logic                         req;
    logic [15:0]                  ptime;
    logic                         hd_armed;
    // Only the checks read these two
    logic [afc_pkg::BP_CNT_W-1:0] jam_len;
    logic [afc_pkg::BP_CNT_W-1:0] jam_lim;
  } afc_fc_s;

  afc_fc_s st_q;
  afc_fc_s st_d;
  logic    jam_start;
  logic    jam_match;
  logic    bp_active;

  // Only the any-frame bit enables full-duplex pause frames
  always_comb begin
    st_d = st_q;
    unique case (st_q.state)
      afc_pkg::AFC_IDLE: begin
        if (full_duplex && on_any_frame_enable
            && high_reached && tx_enable) begin
          st_d.state = afc_pkg::AFC_PAUSE;
          st_d.req   = 1'b1;
          st_d.ptime = pause_time_value;
        end
      end
      afc_pkg::AFC_PAUSE: begin
        if (pause_sent) begin
          st_d.state = afc_pkg::AFC_HELD;
          st_d.req   = 1'b0;
        end else if (!tx_enable) begin
          st_d.state = afc_pkg::AFC_IDLE;
          st_d.req   = 1'b0;
        end
      end
      afc_pkg::AFC_HELD: begin
        if (below_low && tx_enable) begin
          st_d.state = afc_pkg::AFC_RESUME;
          st_d.req   = 1'b1;
          st_d.ptime = 16'h0000;
        end
      end
      afc_pkg::AFC_RESUME: begin
        if (pause_sent) begin
          st_d.state = afc_pkg::AFC_IDLE;
          st_d.req   = 1'b0;
        end else if (!tx_enable) begin
          st_d.state = afc_pkg::AFC_HELD;
          st_d.req   = 1'b0;
        end
      end
    endcase
    // Half-duplex arming runs from the high crossing until below the low level
    if (full_duplex || !auto_enabled) begin
      st_d.hd_armed = 1'b0;
    end else if (high_reached) begin
      st_d.hd_armed = 1'b1;
    end else if (below_low) begin
      st_d.hd_armed = 1'b0;
    end
    // Jam bookkeeping for the checks; unread by the logic, so it costs no gates
    st_d.jam_len = bp_active ? st_q.jam_len + afc_pkg::BP_CNT_W'(1) : '0;
    if (jam_start && !bp_active) begin
      st_d.jam_lim = afc_pkg::bp_cycles(backpressure_time_code, speed_100, PERIOD_NS);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q       <= '0;
      st_q.state <= afc_pkg::AFC_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // ************************************************************
  // Half-duplex jam
  // ************************************************************
  // Any-frame jams at the preamble without waiting for the address
  assign jam_match = on_any_frame_enable ? rx_preamble
                   : rx_header_valid & ((on_multicast_enable & rx_is_multicast)
                                      | (on_broadcast_enable & rx_is_broadcast)
                                      | (on_own_address_enable & rx_is_own_address));
  assign jam_start = st_q.hd_armed & ~full_duplex & tx_enable & jam_match;

  afc_bp_timer #(
    .PERIOD_NS (PERIOD_NS)
  ) u_bp_timer (
    .clock     (clock),
    .rst       (rst),
    .start     (jam_start),
    .stop      (full_duplex | ~tx_enable),
    .code      (backpressure_time_code),
    .speed_100 (speed_100),
    .active    (bp_active)
  );

  assign backpressure   = bp_active;
  assign pause_request  = st_q.req;
  assign pause_time_out = st_q.ptime;
  assign status         = {23'h000000, bp_active, st_q.hd_armed, st_q.state,
                           below_low, high_reached, st_q.req};

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_no_start_tx_off;
    !tx_enable |=> !$rose(pause_request) && !$rose(backpressure);
  endproperty
  a_no_start_tx_off: assert property (p_no_start_tx_off)
    else $error("start while tx off");

  property p_pause_on_high;
    st_q.state == afc_pkg::AFC_IDLE && full_duplex && on_any_frame_enable && high_reached
      && tx_enable |=> pause_request && pause_time_out == $past(pause_time_value);
  endproperty
  a_pause_on_high: assert property (p_pause_on_high)
    else $error("no pause at high");

  property p_single_pause;
    pause_request && pause_sent && pause_time_out != 16'h0000 |=>
      !pause_request [*1] ##0 st_q.state == afc_pkg::AFC_HELD;
  endproperty
  a_single_pause: assert property (p_single_pause)
    else $error("second pause");

  property p_zero_needs_sent;
    $rose(pause_request) && pause_time_out == 16'h0000 |->
      $past(st_q.state) == afc_pkg::AFC_HELD;
  endproperty
  a_zero_needs_sent: assert property (p_zero_needs_sent)
    else $error("zero pause unarmed");

  property p_zero_on_low;
    st_q.state == afc_pkg::AFC_HELD && below_low && tx_enable |=>
      pause_request && pause_time_out == 16'h0000;
  endproperty
  a_zero_on_low: assert property (p_zero_on_low)
    else $error("no zero pause");

  property p_fd_no_jam;
    full_duplex |=> !backpressure;
  endproperty
  a_fd_no_jam: assert property (p_fd_no_jam)
    else $error("jam in full duplex");

  property p_jam_on_match;
    st_q.hd_armed && !full_duplex && tx_enable && !backpressure && jam_match
      |=> backpressure;
  endproperty
  a_jam_on_match: assert property (p_jam_on_match)
    else $error("frame not jammed");

  // Jam length is counted in helper state, far too long for a repetition
  property p_short_jam;
    backpressure && st_q.jam_len == st_q.jam_lim - afc_pkg::BP_CNT_W'(1) |=> !backpressure;
  endproperty
  a_short_jam: assert property (p_short_jam)
    else $error("jam too long");

  property p_jam_full;
    $fell(backpressure) && !$past(full_duplex) && $past(tx_enable) |->
      $past(st_q.jam_len) == st_q.jam_lim - afc_pkg::BP_CNT_W'(1);
  endproperty
  a_jam_full: assert property (p_jam_full)
    else $error("jam too short");

  property p_hd_arm;
    !full_duplex && auto_enabled && high_reached |=> st_q.hd_armed;
  endproperty
  a_hd_arm: assert property (p_hd_arm)
    else $error("not armed at high");

  property p_hd_disarm;
    full_duplex || (below_low && !high_reached) |=> !st_q.hd_armed;
  endproperty
  a_hd_disarm: assert property (p_hd_disarm)
    else $error("armed below low");

  property p_hd_no_pause;
    !full_duplex && st_q.state == afc_pkg::AFC_IDLE |=> !pause_request;
  endproperty
  a_hd_no_pause: assert property (p_hd_no_pause)
    else $error("pause in half duplex");

  property p_any_override;
    on_any_frame_enable && rx_header_valid && !rx_preamble |-> !jam_start;
  endproperty
  a_any_override: assert property (p_any_override)
    else $error("any bit not override");

  property p_rearm;
    st_q.state == afc_pkg::AFC_RESUME && pause_sent |=> st_q.state == afc_pkg::AFC_IDLE;
  endproperty
  a_rearm: assert property (p_rearm)
    else $error("not rearmed");

  c_full_cycle: cover property (st_q.state == afc_pkg::AFC_RESUME && pause_sent);
  c_jam:        cover property ($rose(backpressure));
  c_tx_abort:   cover property (st_q.state == afc_pkg::AFC_PAUSE && !tx_enable);
  c_slow_jam:   cover property ($rose(backpressure) && !speed_100);
  c_header_jam: cover property (jam_start && !on_any_frame_enable);

endmodule

`default_nettype wire

// ### afc_mac_model.sv
`default_nettype none

// ********************
// MAC transmit side
// ********************
module afc_mac_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Pause handshake
  input  wire logic        pause_request,
  input  wire logic [15:0] pause_time_out,
  output logic             pause_sent,
  // Answer delay and record
  input  wire logic [3:0]  delay,
  output int               n_pause,
  output logic [15:0]      last_time
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0] cnt_q;
  logic       done_q;

  // One sent pulse per request; delay models a busy transmit window
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pause_sent <= 1'b0;
      cnt_q      <= 4'h0;
      done_q     <= 1'b0;
      n_pause    <= 0;
      last_time  <= 16'h0000;
    end else begin
      pause_sent <= 1'b0;
      if (!pause_request) begin
        cnt_q  <= 4'h0;
        done_q <= 1'b0;
      end else if (!done_q) begin
        if (cnt_q == delay) begin
          pause_sent <= 1'b1;
          done_q     <= 1'b1;
          n_pause    <= n_pause + 1;
          last_time  <= pause_time_out;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end
endmodule

`default_nettype wire

// ### afc_pkg.sv
`default_nettype none

package afc_pkg;

  // ************************************************************
  // Register map and field layout
  // ************************************************************
  localparam logic [7:0]  CFG_ADDR   = 8'hac;
  localparam logic [7:0]  STAT_ADDR  = 8'hb8;
  localparam logic [31:0] CFG_RESET  = 32'h0000_0000;
  localparam logic [31:0] CFG_WMASK  = 32'h00ff_ffff;
  localparam int          HI_LSB     = 16;
  localparam int          LO_LSB     = 8;
  localparam int          DUR_LSB    = 4;
  localparam int          MULT_BIT   = 3;
  localparam int          BRD_BIT    = 2;
  localparam int          ADDR_BIT   = 1;
  localparam int          ANY_BIT    = 0;

  // ************************************************************
  // Fill level and timing
  // ************************************************************
  localparam int          FILL_W        = 14;
  localparam int          THRESH_SHIFT  = 6;
  localparam int          BP_CNT_W      = 13;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned BP_10M_XTRA_NS = 2200;

  typedef enum logic [3:0] {
    AFC_IDLE   = 4'b0001,
    AFC_PAUSE  = 4'b0010,
    AFC_HELD   = 4'b0100,
    AFC_RESUME = 4'b1000
  } afc_state_e;

  // Threshold field in 64-byte units to a byte count
  function automatic logic [FILL_W-1:0] thresh_bytes(input logic [7:0] units);
    thresh_bytes = {units, 6'h00};
  endfunction

  // Backpressure length in ns at 100 Mbps
  function automatic int unsigned bp_ns(input logic [3:0] code);
    case (code)
      4'h0:    bp_ns = 5000;
      4'h1:    bp_ns = 10000;
      4'h2:    bp_ns = 15000;
      4'h3:    bp_ns = 25000;
      default: bp_ns = (int'(code) - 3) * 50000;
    endcase
  endfunction

  // Least time, so round up to whole cycles
  function automatic logic [BP_CNT_W-1:0] bp_cycles(input logic [3:0] code,
                                                    input logic speed_100,
                                                    input int unsigned period_ns);
    int unsigned ns;
    ns = bp_ns(code) + (speed_100 ? 0 : BP_10M_XTRA_NS);
    bp_cycles = BP_CNT_W'((ns + period_ns - 1) / period_ns);
  endfunction

endpackage

`default_nettype wire

// ### testbench.sv
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  // A 1000 ns period, ten times the 100 ns clock, keeps the longest jam near 600 cycles
  localparam int unsigned PER = 1000;
  localparam logic [7:0]  CFG = afc_pkg::CFG_ADDR;

  logic                       clock, rst, read, write, waitrequest;
  logic                       tx_enable, full_duplex, speed_100;
  logic                       rx_preamble, rx_header_valid;
  logic                       rx_is_multicast, rx_is_broadcast, rx_is_own_address;
  logic                       pause_request, pause_sent, backpressure, spd;
  logic [7:0]                 address;
  logic [31:0]                writedata, readdata, q, d;
  logic [3:0]                 byteenable, dly, code;
  logic [15:0]                pause_time_value, pause_time_out, last_time, ptv;
  logic [afc_pkg::FILL_W-1:0] rx_fifo_bytes;
  int                         n_errors, checks, n_pause, len;

  afc_flow_ctrl #(.PERIOD_NS(PER)) uut (
    .clock(clock), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .tx_enable(tx_enable), .full_duplex(full_duplex),
    .speed_100(speed_100), .pause_time_value(pause_time_value),
    .rx_fifo_bytes(rx_fifo_bytes), .rx_preamble(rx_preamble),
    .rx_header_valid(rx_header_valid), .rx_is_multicast(rx_is_multicast),
    .rx_is_broadcast(rx_is_broadcast), .rx_is_own_address(rx_is_own_address),
    .pause_request(pause_request), .pause_time_out(pause_time_out),
    .pause_sent(pause_sent), .backpressure(backpressure));

  afc_mac_model mac (
    .clock(clock), .rst(rst), .pause_request(pause_request),
    .pause_time_out(pause_time_out), .pause_sent(pause_sent), .delay(dly),
    .n_pause(n_pause), .last_time(last_time));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // ********************
  // Checks and report
  // ********************
  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (e !== s) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic hang(input string nm);
    n_errors++;
    $display("[ERR] %s expected done seen timeout", nm);
    results();
  endtask

  // Jam length: 5,10,15,25 us, then 50 us steps; slow link adds 2.2 us
  function automatic int exp_len(input logic [3:0] c, input logic s);
    int ns;
    ns = (c < 4'h4) ? ((c == 4'h3) ? 25000 : (int'(c) + 1) * 5000) : (int'(c) - 3) * 50000;
    if (!s)
      ns += 2200;
    return (ns + PER - 1) / PER;
  endfunction

  // ********************
  // Drivers
  // ********************
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v,
                     input logic [3:0] be);
    int n;
    @(posedge clock);
    address    <= a;
    writedata  <= v;
    byteenable <= be;
    write      <= w;
    read       <= !w;
    n = 0;
    // Sampled at the rising edge, before that edge's updates land
    do begin
      @(posedge clock);
      n++;
      if (n > 20)
        hang("waitrequest");
    end while (waitrequest !== 1'b0);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge clock);
  endtask

  task automatic wait_np(input int t);
    int n;
    n = 0;
    while (n_pause != t) begin
      n++;
      if (n > 60)
        hang("pause frame");
      @(posedge clock);
    end
  endtask

  // Frame event, then count jam cycles over a window past the longest jam
  task automatic jam(input logic pre, input logic [3:0] fl, output int l);
    @(posedge clock);
    rx_preamble       <= pre;
    rx_header_valid   <= !pre;
    rx_is_multicast   <= fl[3];
    rx_is_broadcast   <= fl[2];
    rx_is_own_address <= fl[1];
    @(posedge clock);
    rx_preamble     <= 1'b0;
    rx_header_valid <= 1'b0;
    l = 0;
    repeat (620) begin
      @(negedge clock);
      if (backpressure === 1'b1)
        l++;
    end
    @(posedge clock);
  endtask

  // ********************
  // Main sequence
  // ********************
  initial begin
    {read, write, tx_enable, full_duplex, speed_100, rx_preamble} = '0;
    {rx_header_valid, rx_is_multicast, rx_is_broadcast, rx_is_own_address} = '0;
    {address, writedata, byteenable, pause_time_value, rx_fifo_bytes} = '0;
    n_errors = 0;
    checks = 0;
    dly = 4'h3;
    rst = 1'b1;
    void'($urandom(44143));
    idle(6);
    rst <= 1'b0;
    bus(1'b0, CFG, 32'h0, 4'hf);
    chk("cfg reset", afc_pkg::CFG_RESET, q);
    bus(1'b1, CFG, 32'hffff_ffff, 4'hf);
    bus(1'b0, CFG, 32'h0, 4'hf);
    chk("cfg mask", 32'h00ff_ffff, q);
    bus(1'b1, CFG, 32'h0, 4'h2);
    bus(1'b0, CFG, 32'h0, 4'hf);
    chk("cfg lane", 32'h00ff_00ff, q);
    bus(1'b1, 8'h40, $urandom, 4'hf);
    bus(1'b0, 8'h40, 32'h0, 4'hf);
    chk("unmapped", 32'h0, q);
    d = $urandom;
    bus(1'b1, CFG, d, 4'hf);
    bus(1'b0, CFG, 32'h0, 4'hf);
    chk("cfg random", d & 32'h00ff_ffff, q);
    $display("test registers done");

    // Config first: the random word above may hold a zero high level
    ptv = 16'($urandom_range(1, 65535));
    bus(1'b1, CFG, 32'h0004_0201, 4'hf);
    pause_time_value <= ptv;
    full_duplex      <= 1'b1;
    tx_enable        <= 1'b1;
    speed_100        <= 1'b1;
    rx_fifo_bytes <= 14'd255;
    idle(20);
    chk("below high", 0, n_pause);
    rx_fifo_bytes <= 14'd256;
    wait_np(1);
    chk("pause time", ptv, last_time);
    jam(1'b1, 4'h0, len);
    chk("full duplex jam", 0, len);
    chk("single pause", 1, n_pause);
    bus(1'b0, afc_pkg::STAT_ADDR, 32'h0, 4'hf);
    chk("status held", 32'h0000_0022, q);
    rx_fifo_bytes <= 14'd128;
    idle(20);
    chk("at low", 1, n_pause);
    dly <= 4'hc;
    rx_fifo_bytes <= 14'd127;
    wait_np(2);
    chk("resume time", 16'h0, last_time);
    rx_fifo_bytes <= 14'd256;
    wait_np(3);
    chk("rearmed", ptv, last_time);
    rx_fifo_bytes <= 14'd0;
    wait_np(4);
    $display("test full duplex done");

    tx_enable <= 1'b0;
    rx_fifo_bytes <= 14'd300;
    idle(20);
    chk("tx off pause", 4, n_pause);
    chk("tx off request", 1'b0, pause_request);
    rx_fifo_bytes <= 14'd0;
    idle(5);
    tx_enable <= 1'b1;
    idle(20);
    chk("no resume", 4, n_pause);
    $display("test transmitter off done");

    full_duplex <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      code = (i == 0) ? 4'hf : 4'($urandom);
      spd = ~i[0];
      speed_100 <= spd;
      rx_fifo_bytes <= 14'd0;
      idle(3);
      bus(1'b1, CFG, {8'h00, 8'h04, 8'h02, code, 4'(1 << i)}, 4'hf);
      rx_fifo_bytes <= 14'd256;
      idle(3);
      jam(i == 0, ~4'(1 << i), len);
      chk("no match", (i == 0) ? exp_len(code, spd) : 0, len);
      jam(i == 0, 4'(1 << i), len);
      chk("jam length", exp_len(code, spd), len);
    end
    tx_enable <= 1'b0;
    jam(1'b0, 4'h8, len);
    chk("tx off jam", 0, len);
    $display("test half duplex done");
    results();
  end
endmodule

`default_nettype wire
